//--- include/rfd_pkg.sv
// Constants and carrier types of the reader carrier and demodulator core
package rfd_pkg;
    // Clock and internal 16 MHz tick
    localparam int CLK_MHZ    = 250;
    localparam int TICK_MHZ   = 16;
    localparam logic [7:0] TICK_STEP = 8'h10;
    localparam logic [7:0] TICK_MOD  = 8'hFA;
    // Times as printed
    localparam int SLEEP_MS   = 100;
    localparam int RETRY_MS   = 10;
    localparam int DIAG_WIN_US = 100;
    localparam int DIAG_DLY_MS = 2;
    localparam int HOLD_MS    = 1;
    localparam int SLEEP_CYC  = SLEEP_MS * CLK_MHZ * 1000;
    localparam int RETRY_CYC  = RETRY_MS * CLK_MHZ * 1000;
    localparam int DIAG_WIN_CYC = DIAG_WIN_US * CLK_MHZ;
    localparam int DIAG_DLY_CYC = DIAG_DLY_MS * CLK_MHZ * 1000;
    localparam int HOLD_CYC   = HOLD_MS * CLK_MHZ * 1000;
    // Carrier divider and bridge timing, in 16 MHz ticks
    localparam logic [6:0] DIV_DEF = 7'h77;
    localparam logic [6:0] DIV_MIN = 7'h72;
    localparam logic [6:0] DIV_MAX = 7'h7C;
    localparam logic [6:0] DEAD_TICKS = 7'h0C;
    localparam logic [6:0] PHASE_DIV  = 7'h14;
    // Demodulator
    localparam logic [7:0] PER_MIN = 8'h70;
    localparam logic [7:0] PER_MAX = 8'h7D;
    localparam logic [7:0] HYST_HI = 8'h05;
    localparam logic [7:0] HYST_LO = 8'h07;
    localparam logic [11:0] SR_START = 12'h00F;
    localparam logic [4:0] BIT_PERIODS = 5'h10;
    localparam logic [7:0] DIAG_OK   = 8'hAF;
    localparam logic [7:0] DIAG_FAIL = 8'hFF;
    // Register map and control bit
    localparam logic [4:0] REG_DIV  = 5'h00;
    localparam logic [4:0] REG_CTRL = 5'h04;
    localparam logic [4:0] REG_STAT = 5'h08;
    localparam logic [4:0] REG_AVG  = 5'h0C;
    localparam logic [4:0] REG_RX   = 5'h10;
    localparam int CTRL_SYNC_BIT = 0;

    typedef enum logic [1:0] {
        PH_IDLE   = 2'b00,
        PH_MEAS   = 2'b01,
        PH_SEARCH = 2'b10,
        PH_DATA   = 2'b11
    } rfd_phase_t;

    typedef struct packed {
        logic hsA_n;
        logic hsB_n;
        logic lsA;
        logic lsB;
    } rfd_gate_t;

    typedef struct packed {
        logic       valid;
        logic       diag;
        logic [7:0] data;
    } rfd_byte_t;
endpackage

//--- core/rfd_carrier_demod.sv
// Reader core: sleep, carrier bridge, short protection, diagnosis, FSK demodulator
//
// Our own choices: the address map and the address-and-strobe port.
`timescale 1ns/1ps
module rfd_carrier_demod import rfd_pkg::*; #(
    parameter int SLEEP_CYCLES = SLEEP_CYC,
    parameter int RETRY_CYCLES = RETRY_CYC,
    parameter int WIN_CYCLES   = DIAG_WIN_CYC,
    parameter int DLY_CYCLES   = DIAG_DLY_CYC,
    parameter int HOLD_CYCLES  = HOLD_CYC
) (
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        rst_n,
    // Pins from outside
    input  wire logic        hostCtl,
    input  wire logic        factorSel,
    input  wire logic        rxLimited,
    input  wire logic [1:0]  shortDet,
    // Phase controls from the sequencer
    input  wire logic        chargeOn,
    input  wire logic        writeMode,
    input  wire logic        writeOn,
    input  wire logic        readOn,
    // Register port
    input  wire logic [4:0]  regAddr,
    input  wire logic [15:0] regWdata,
    input  wire logic        regWr,
    input  wire logic        regRd,
    output logic      [15:0] regRdata,
    // Bridge and analog controls
    output rfd_gate_t        gate,
    output logic             diagLoad,
    output logic             oscRun,
    output logic      [3:0]  pllFactor,
    output logic             asleep,
    // Byte stream to host encoder
    output rfd_byte_t        byteOut
);
    localparam int SW = $clog2(SLEEP_CYCLES + 1);
    localparam int RW = $clog2(RETRY_CYCLES + 1);
    localparam int DW = $clog2(DLY_CYCLES + WIN_CYCLES + 1);
    localparam int HW = $clog2(HOLD_CYCLES + 1);

    if (SLEEP_CYCLES < 1 || RETRY_CYCLES < 1 || WIN_CYCLES < 1 || HOLD_CYCLES < 1
        || DLY_CYCLES < WIN_CYCLES) begin : g_bad
        $error("rfd_carrier_demod: timing parameters out of range");
    end

    typedef struct packed {
        logic [1:0]       hostS;
        logic [1:0]       selS;
        logic [2:0]       rxS;
        logic [1:0][1:0]  shS;
        logic [SW-1:0]    hiCnt;
        logic             asleep;
        logic [7:0]       acc;
        logic [6:0]       div;
        logic             syncMode;
        logic [6:0]       divCnt;
        logic             act;
        logic             wrPrev;
        logic             alPend;
        logic             alWait;
        logic [6:0]       alCnt;
        logic [1:0]       off;
        logic [1:0][RW-1:0] retry;
        logic             chPrev;
        logic [DW-1:0]    dTmr;
        logic [2:0]       dRun;
        logic             dPass;
        logic             shSeen;
        logic             dSent;
        logic [HW-1:0]    hold;
        logic [7:0]       perCnt;
        rfd_phase_t       ph;
        logic [2:0]       mRun;
        logic [10:0]      sum;
        logic [7:0]       avg;
        logic             rawPrev;
        logic             filt;
        logic [11:0]      sr;
        logic [4:0]       perIdx;
        logic [2:0]       bitCnt;
        logic [7:0]       byteSr;
        logic [7:0]       lastRx;
        rfd_gate_t        gate;
        logic             diagLoad;
        logic             oscRun;
        logic [3:0]       pllFactor;
        rfd_byte_t        byteOut;
        logic [15:0]      rdata;
    } rfd_state_t;

    rfd_state_t q, d;
    logic       tick;
    logic [8:0] accSum;
    logic       rxEdge;
    logic [7:0] per;
    logic       inRange;
    logic [7:0] thr;
    logic       raw;
    logic [6:0] half;
    logic       drive;

    always_comb begin
        d = q;
        tick = 1'b0;
        accSum = 9'h000;
        rxEdge = 1'b0;
        per = q.perCnt;
        inRange = 1'b0;
        thr = 8'h00;
        raw = 1'b0;
        half = q.div >> 1;
        drive = 1'b0;
        d.byteOut.valid = 1'b0;

        // Pin synchronisers
        d.hostS = {q.hostS[0], hostCtl};
        d.selS = {q.selS[0], factorSel};
        d.rxS = {q.rxS[1:0], rxLimited};
        for (int k = 0; k < 2; k++) begin
            d.shS[k] = {q.shS[k][0], shortDet[k]};
        end

        // Sleep entry and wake
        if (!q.hostS[1]) begin
            d.hiCnt = '0;
            d.asleep = 1'b0;
        end else if (q.hiCnt < SW'(SLEEP_CYCLES)) begin
            d.hiCnt = q.hiCnt + SW'(1);
        end else begin
            d.asleep = 1'b1;
        end
        d.oscRun = !d.asleep;
        d.pllFactor = q.selS[1] ? 4'h4 : 4'h8;

        // 16 MHz tick from a fractional accumulator, stopped while asleep
        accSum = {1'b0, q.acc} + {1'b0, TICK_STEP};
        if (q.asleep) begin
            d.acc = 8'h00;
        end else if (accSum >= {1'b0, TICK_MOD}) begin
            d.acc = 8'(accSum - {1'b0, TICK_MOD});
            tick = 1'b1;
        end else begin
            d.acc = accSum[7:0];
        end

        // Period counting on the limited input
        rxEdge = q.rxS[1] && !q.rxS[2];
        if (rxEdge) begin
            d.perCnt = tick ? 8'h01 : 8'h00;
        end else if (tick && q.perCnt != 8'hFF) begin
            d.perCnt = q.perCnt + 8'h01;
        end
        inRange = per >= PER_MIN && per <= PER_MAX;

        // Short protection per output
        for (int k = 0; k < 2; k++) begin
            if (q.off[k]) begin
                if (q.retry[k] == '0) begin
                    d.off[k] = 1'b0;
                end else begin
                    d.retry[k] = q.retry[k] - RW'(1);
                end
            end else if (q.act && q.shS[k][1]) begin
                d.off[k] = 1'b1;
                d.retry[k] = RW'(RETRY_CYCLES - 1);
            end
        end

        // Diagnosis during charge
        d.chPrev = chargeOn;
        if (chargeOn && !q.chPrev) begin
            d.dTmr = '0;
            d.dRun = 3'h0;
            d.dPass = 1'b0;
            d.shSeen = 1'b0;
            d.dSent = 1'b0;
        end else if (chargeOn && q.dTmr < DW'(DLY_CYCLES)) begin
            d.dTmr = q.dTmr + DW'(1);
        end
        if (chargeOn && q.off != 2'b00) begin
            d.shSeen = 1'b1;
        end
        // Stale run count from an earlier charge must not count in the first cycle
        if (chargeOn && q.chPrev && rxEdge && q.dTmr < DW'(WIN_CYCLES) && !q.dPass) begin
            if (inRange) begin
                d.dRun = q.dRun + 3'h1;
                if (q.dRun == 3'h7) begin
                    d.dPass = 1'b1;
                end
            end else begin
                d.dRun = 3'h0;
            end
        end
        if (chargeOn && !q.dSent && q.dTmr == DW'(DLY_CYCLES)) begin
            d.dSent = 1'b1;
            d.byteOut.valid = 1'b1;
            d.byteOut.diag = 1'b1;
            d.byteOut.data = (q.dPass && !q.shSeen) ? DIAG_OK : DIAG_FAIL;
            if (q.syncMode) begin
                d.hold = HW'(HOLD_CYCLES);
            end
        end else if (q.hold != '0) begin
            d.hold = q.hold - HW'(1);
        end
        d.diagLoad = chargeOn && !readOn;

        // Write-mode phase alignment after a bit pause
        d.wrPrev = writeOn;
        if (writeMode && writeOn && !q.wrPrev) begin
            d.alPend = 1'b1;
            d.alWait = 1'b0;
        end
        if (!writeOn) begin
            d.alPend = 1'b0;
        end
        if (q.alPend && !q.alWait && rxEdge) begin
            d.alWait = 1'b1;
            d.alCnt = q.div / PHASE_DIV;
        end
        if (q.alWait && tick) begin
            if (q.alCnt == 7'h00) begin
                d.alPend = 1'b0;
                d.alWait = 1'b0;
                d.divCnt = 7'h00;
            end else begin
                d.alCnt = q.alCnt - 7'h01;
            end
        end

        // Carrier divider and bridge gates
        // Next pending flag, so no single gate pulse escapes before alignment
        drive = chargeOn || (writeOn && !d.alPend) || q.hold != '0;
        d.act = drive;
        if (tick && !(q.alWait && q.alCnt == 7'h00)) begin
            d.divCnt = (q.divCnt >= q.div - 7'h01) ? 7'h00 : q.divCnt + 7'h01;
        end
        // Equal on-times of half minus dead time; odd factors add one tick to the dead time after B
        d.gate.hsA_n = !(q.act && !q.off[0] && q.divCnt < half - DEAD_TICKS);
        d.gate.hsB_n = !(q.act && !q.off[1] && q.divCnt >= half
                         && q.divCnt < half + half - DEAD_TICKS);
        d.gate.lsA = !q.act || !d.gate.hsB_n;
        d.gate.lsB = !q.act || !d.gate.hsA_n;

        // Demodulator
        thr = q.avg + (q.filt ? HYST_HI : HYST_LO);
        raw = per > thr;
        if (chargeOn || !(readOn || writeOn)) begin
            d.ph = PH_IDLE;
        end else begin
            unique case (q.ph)
                PH_IDLE: begin
                    d.ph = PH_MEAS;
                    d.mRun = 3'h0;
                    d.sum = 11'h000;
                end
                PH_MEAS: begin
                    if (rxEdge) begin
                        if (inRange) begin
                            d.sum = q.sum + {3'h0, per};
                            d.mRun = q.mRun + 3'h1;
                            if (q.mRun == 3'h7) begin
                                d.avg = d.sum[10:3];
                                d.ph = PH_SEARCH;
                                d.sr = 12'h000;
                                d.filt = 1'b0;
                                d.rawPrev = 1'b0;
                            end
                        end else begin
                            d.mRun = 3'h0;
                            d.sum = 11'h000;
                        end
                    end
                end
                PH_SEARCH, PH_DATA: begin
                    if (rxEdge) begin
                        d.rawPrev = raw;
                        if (raw == q.rawPrev) begin
                            d.filt = raw;
                        end
                        d.sr = {q.sr[10:0], d.filt};
                        if (q.ph == PH_SEARCH && d.sr == SR_START) begin
                            d.ph = PH_DATA;
                            d.perIdx = 5'h00;
                            d.bitCnt = 3'h0;
                        end else if (q.ph == PH_DATA) begin
                            d.perIdx = q.perIdx + 5'h01;
                            if (q.perIdx == BIT_PERIODS - 5'h01) begin
                                d.perIdx = 5'h00;
                                d.byteSr = {d.filt, q.byteSr[7:1]};
                                d.bitCnt = q.bitCnt + 3'h1;
                                if (q.bitCnt == 3'h7 && !d.byteOut.valid) begin
                                    d.byteOut.valid = 1'b1;
                                    d.byteOut.diag = 1'b0;
                                    d.byteOut.data = d.byteSr;
                                    d.lastRx = d.byteSr;
                                end
                            end
                        end
                    end
                end
            endcase
        end

        // Register port; a bad divider value is ignored
        if (regWr) begin
            if (regAddr == REG_DIV && regWdata[6:0] >= DIV_MIN && regWdata[6:0] <= DIV_MAX
                && regWdata[15:7] == 9'h000) begin
                d.div = regWdata[6:0];
            end
            if (regAddr == REG_CTRL) begin
                d.syncMode = regWdata[CTRL_SYNC_BIT];
            end
        end
        d.rdata = 16'h0000;
        if (regRd) begin
            unique case (regAddr)
                REG_DIV:  d.rdata = {9'h000, q.div};
                REG_CTRL: d.rdata = {15'h0000, q.syncMode};
                REG_STAT: d.rdata = {8'h00, q.asleep, q.dPass, q.shSeen, q.off, q.act, q.ph};
                REG_AVG:  d.rdata = {8'h00, q.avg};
                REG_RX:   d.rdata = {8'h00, q.lastRx};
                default:  d.rdata = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            q <= '0;
            q.div <= DIV_DEF;
            q.ph <= PH_IDLE;
            q.gate <= '{hsA_n: 1'b1, hsB_n: 1'b1, lsA: 1'b1, lsB: 1'b1};
            q.oscRun <= 1'b1;
            q.pllFactor <= 4'h8;
        end else begin
            q <= d;
        end
    end

    assign regRdata  = q.rdata;
    assign gate      = q.gate;
    assign diagLoad  = q.diagLoad;
    assign oscRun    = q.oscRun;
    assign pllFactor = q.pllFactor;
    assign asleep    = q.asleep;
    assign byteOut   = q.byteOut;

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_n);

    property p_wake;
        q.asleep && !q.hostS[1] |=> !q.asleep;
    endproperty
    a_wake: assert property (p_wake) else $error("sleep not left on low line");

    property p_sleepEntry;
        $rose(q.asleep) |-> $past(q.hiCnt) == SW'(SLEEP_CYCLES) && $past(q.hostS[1]);
    endproperty
    a_sleepEntry: assert property (p_sleepEntry) else $error("sleep entered early");

    property p_noTick;
        q.asleep |-> !tick && !q.oscRun ##1 q.acc == 8'h00;
    endproperty
    a_noTick: assert property (p_noTick) else $error("clock runs while asleep");

    property p_dead;
        $rose(q.gate.hsA_n) |-> q.gate.hsB_n [*8];
    endproperty
    a_dead: assert property (p_dead) else $error("dead time violated");

    property p_ground;
        !q.act |=> q.gate.lsA && q.gate.lsB && q.gate.hsA_n && q.gate.hsB_n;
    endproperty
    a_ground: assert property (p_ground) else $error("idle bridge not grounded");

    property p_short;
        q.act && q.shS[0][1] && !q.off[0] |=> q.off[0] ##1 q.gate.hsA_n;
    endproperty
    a_short: assert property (p_short) else $error("short not shut off");

    property p_diagFail;
        byteOut.valid && byteOut.diag && (!$past(q.dPass) || $past(q.shSeen))
            |-> byteOut.data == DIAG_FAIL;
    endproperty
    a_diagFail: assert property (p_diagFail) else $error("wrong failure byte");

    property p_loadOff;
        readOn |=> !q.diagLoad;
    endproperty
    a_loadOff: assert property (p_loadOff) else $error("diag load on in read");

    property p_start;
        q.ph == PH_DATA && $past(q.ph) == PH_SEARCH |-> q.sr == SR_START;
    endproperty
    a_start: assert property (p_start) else $error("start bit without pattern");

    property p_avg;
        q.ph == PH_SEARCH |-> q.avg >= PER_MIN && q.avg <= PER_MAX;
    endproperty
    a_avg: assert property (p_avg) else $error("average out of range");

    property p_div;
        q.div >= DIV_MIN && q.div <= DIV_MAX;
    endproperty
    a_div: assert property (p_div) else $error("divider out of range");
endmodule // rfd_carrier_demod

//--- tb/rfd_rx_source.sv
// Transponder side model: limited receive signal with a set period
`timescale 1ns/1ps
module rfd_rx_source (
    // Control from bench
    input  wire logic       en,
    input  wire logic [7:0] perTicks,
    // Limiter pin
    output logic            rxLimited
);
    // Period in 16 MHz ticks of 62.5 ns; with no field the limiter rests low
    always begin
        rxLimited = 1'b0;
        wait (en);
        while (en) begin
            rxLimited = 1'b1;
            #(perTicks * 31.25);
            rxLimited = 1'b0;
            #(perTicks * 31.25);
        end
    end
endmodule // rfd_rx_source

//--- tb/rfd_carrier_demod_bench.sv
// Self-checking bench of the reader carrier and demodulator core
`timescale 1ns/1ps
module rfd_carrier_demod_bench import rfd_pkg::*;;
    typedef struct packed {logic [4:0] a; logic [15:0] w; logic [15:0] e;} rfd_row_t;
    logic        mclk, rst_n, hostCtl, factorSel, chargeOn, writeMode, writeOn, readOn;
    logic        regWr, regRd, rxEn, rxLimited, diagLoad, oscRun, asleep, sawA, sawB;
    logic [1:0]  shortDet, hsPrev;
    logic [4:0]  regAddr;
    logic [15:0] regWdata, regRdata, rd;
    logic [7:0]  perTicks;
    logic [3:0]  pllFactor;
    rfd_gate_t   gate;
    rfd_byte_t   byteOut;
    rfd_row_t    rows [10];
    int          error_cnt, n_tests, cyc, offAt, minGap, i;

    rfd_rx_source rfd_rx_source_inst (.en(rxEn), .perTicks(perTicks), .rxLimited(rxLimited));

    // Counts shortened so the whole run stays short
    rfd_carrier_demod #(.SLEEP_CYCLES(200), .RETRY_CYCLES(5000), .WIN_CYCLES(16000),
        .DLY_CYCLES(16000), .HOLD_CYCLES(200)) rfd_carrier_demod_inst (
        .mclk(mclk), .rst_n(rst_n), .hostCtl(hostCtl), .factorSel(factorSel),
        .rxLimited(rxLimited), .shortDet(shortDet), .chargeOn(chargeOn), .writeMode(writeMode),
        .writeOn(writeOn), .readOn(readOn), .regAddr(regAddr), .regWdata(regWdata),
        .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .gate(gate), .diagLoad(diagLoad),
        .oscRun(oscRun), .pllFactor(pllFactor), .asleep(asleep), .byteOut(byteOut));

    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end

    // Sampled on the falling edge, away from the registered gate updates
    always @(negedge mclk) begin
        cyc = cyc + 1;
        if (!gate.hsA_n) sawA = 1'b1;
        if (!gate.hsB_n) sawB = 1'b1;
        if ((gate.hsA_n && !hsPrev[1]) || (gate.hsB_n && !hsPrev[0])) offAt = cyc;
        if (((!gate.hsA_n && hsPrev[1]) || (!gate.hsB_n && hsPrev[0])) && offAt > 0
            && cyc - offAt < minGap) minGap = cyc - offAt;
        hsPrev = {gate.hsA_n, gate.hsB_n};
    end

    task automatic wt(input int n);
        repeat (n) @(posedge mclk);
    endtask

    task automatic chk(input logic [15:0] exp, input logic [15:0] got);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask

    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(posedge mclk);
        regWr <= 1'b1;
        regAddr <= a;
        regWdata <= d;
        @(posedge mclk);
        regWr <= 1'b0;
    endtask

    task automatic rdreg(input logic [4:0] a, output logic [15:0] d);
        @(posedge mclk);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge mclk);
        regRd <= 1'b0;
        #1 d = regRdata;
    endtask

    task automatic tdone(input string s);
        $display("test %s done", s);
    endtask

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // One charge phase; a short on output A may be applied partway; sync mode holds the bridge
    task automatic charge(input logic [7:0] per, input logic shA, input logic syn, input logic [15:0] expByte);
        @(posedge mclk);
        perTicks <= per;
        rxEn <= 1'b1;
        chargeOn <= 1'b1;
        wt(1000);
        #1 chk(16'h0001, {15'h0, diagLoad});
        if (shA) begin
            @(posedge mclk);
            shortDet <= 2'b01;
            wt(10);
            sawA = 1'b0;
            sawB = 1'b0;
            wt(4000);
            #1 chk(16'h0002, {14'h0, sawB, sawA});
            @(posedge mclk);
            shortDet <= 2'b00;
            wt(3000);
            #1 chk(16'h0001, {15'h0, sawA});
        end
        for (i = 0; i < 20500 && byteOut.valid !== 1'b1; i++) begin
            @(posedge mclk);
            #1;
        end
        chk(expByte, {6'h0, byteOut});
        @(posedge mclk);
        chargeOn <= 1'b0;
        rxEn <= 1'b0;
        wt(100);
        rdreg(REG_STAT, rd);
        chk({15'h0, syn}, {15'h0, rd[2]});
        wt(300);
        #1 chk(16'h000F, {12'h0, gate});
    endtask

    initial begin
        {rst_n, hostCtl, factorSel, chargeOn, writeMode, writeOn, readOn, regWr, regRd, rxEn} = '0;
        {shortDet, regAddr, regWdata} = '0;
        perTicks = 8'h77;
        {error_cnt, n_tests, cyc, offAt} = '0;
        minGap = 1000000;
        {sawA, sawB} = '0;
        hsPrev = 2'b11;
        rows = '{'{REG_DIV, 16'h0072, 16'h0072}, '{REG_DIV, 16'h007C, 16'h007C},
                 '{REG_DIV, 16'h0071, 16'h007C}, '{REG_DIV, 16'h007D, 16'h007C},
                 '{REG_DIV, 16'h00F7, 16'h007C}, '{REG_CTRL, 16'h0001, 16'h0001},
                 '{REG_CTRL, 16'h0000, 16'h0000}, '{5'h14, 16'hFFFF, 16'h0000},
                 '{REG_AVG, 16'hFFFF, 16'h0000}, '{REG_DIV, 16'h0077, 16'h0077}};
        wt(3);
        rst_n <= 1'b1;
        #1 chk(16'h000F, {12'h0, gate});
        chk(16'h0008, {12'h0, pllFactor});
        chk(16'h0001, {15'h0, oscRun});
        rdreg(REG_DIV, rd);
        chk(16'h0077, rd);
        tdone("reset");
        foreach (rows[k]) begin
            wr(rows[k].a, rows[k].w);
            rdreg(rows[k].a, rd);
            chk(rows[k].e, rd);
        end
        tdone("registers");
        @(posedge mclk);
        factorSel <= 1'b1;
        wt(6);
        #1 chk(16'h0004, {12'h0, pllFactor});
        @(posedge mclk);
        factorSel <= 1'b0;
        wt(6);
        #1 chk(16'h0008, {12'h0, pllFactor});
        tdone("factor");
        // A short low pulse must restart the sleep count
        @(posedge mclk);
        hostCtl <= 1'b1;
        wt(150);
        hostCtl <= 1'b0;
        wt(10);
        hostCtl <= 1'b1;
        wt(195);
        #1 chk(16'h0000, {15'h0, asleep});
        for (i = 0; i < 20 && asleep !== 1'b1; i++) begin
            @(posedge mclk);
            #1;
        end
        chk(16'h0001, {15'h0, asleep});
        chk(16'h0000, {15'h0, oscRun});
        @(posedge mclk);
        hostCtl <= 1'b0;
        wt(8);
        #1 chk(16'h0000, {15'h0, asleep});
        chk(16'h0001, {15'h0, oscRun});
        tdone("sleep");
        charge(8'h77, 1'b0, 1'b0, 16'h03AF);
        chk(16'h0001, {15'h0, minGap >= 186});
        tdone("diag pass");
        wr(REG_CTRL, 16'h0001);
        charge(8'h6E, 1'b0, 1'b1, 16'h03FF);
        wr(REG_CTRL, 16'h0000);
        tdone("diag fail");
        charge(8'h77, 1'b1, 1'b0, 16'h03FF);
        tdone("short");
        // Diagnosis load must stay off in read even while charge is up
        @(posedge mclk);
        chargeOn <= 1'b1;
        readOn <= 1'b1;
        wt(4);
        #1 chk(16'h0000, {15'h0, diagLoad});
        @(posedge mclk);
        chargeOn <= 1'b0;
        readOn <= 1'b0;
        // Write phase: bridge waits for the first received edge, then the demodulator locks on
        @(posedge mclk);
        perTicks <= 8'h77;
        rxEn <= 1'b1;
        writeMode <= 1'b1;
        writeOn <= 1'b1;
        wt(20);
        #1 chk(16'h000F, {12'h0, gate});
        wt(300);
        #1 chk(16'h0000, {15'h0, gate.hsA_n});
        wt(15180);
        rdreg(REG_AVG, rd);
        chk(16'h0001, {15'h0, rd >= 16'h0076 && rd <= 16'h0078});
        @(posedge mclk);
        perTicks <= 8'h82;
        wt(14300);
        rdreg(REG_STAT, rd);
        chk(16'h0003, {14'h0, rd[1:0]});
        @(posedge mclk);
        rxEn <= 1'b0;
        writeMode <= 1'b0;
        writeOn <= 1'b0;
        tdone("write and demod");
        wr(REG_DIV, 16'h0072);
        @(posedge mclk);
        rst_n <= 1'b0;
        wt(3);
        rst_n <= 1'b1;
        rdreg(REG_DIV, rd);
        chk(16'h0077, rd);
        tdone("second reset");
        wrap_up;
    end

    initial begin
        wt(95000);
        error_cnt++;
        wrap_up;
    end
endmodule // rfd_carrier_demod_bench
